// File: dv/hoa_checker.sv
// concurrent checks on the heater-open alarm top ports
module hoa_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        clkEn,
    input wire logic        heatOnPin,
    input wire logic        coolOnPin,
    input wire logic [10:0] senseCurrent,
    input wire logic        sensePresent,
    input wire logic [4:0]  avsAddress,
    input wire logic        avsRead,
    input wire logic        avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0]  avsByteEnable,
    input wire logic [31:0] avsReadData,
    input wire logic        avsWaitRequest,
    input wire logic        heaterOpenAlarm,
    input wire logic        heatOut
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // a read answered at this edge
    wire logic rdDone = avsRead && !avsWaitRequest;
    //////////////////////////////////////////////////////////////////////////
    a_reset_quiet:
        assert property ($fell(rst) |-> avsWaitRequest && !heaterOpenAlarm && !heatOut
            && avsReadData == 32'h0000_0000) else $error("outputs busy after reset");
    a_one_wait:
        assert property ((avsRead || avsWrite) && avsWaitRequest && clkEn |=> !avsWaitRequest)
            else $error("request not answered after one wait cycle");
    a_wait_single:
        assert property (!avsWaitRequest && clkEn |=> avsWaitRequest)
            else $error("answer held longer than one cycle");
    // the alarm must never bend the control output, whatever its state
    a_heat_pass:
        assert property (clkEn [*4] |-> heatOut == $past(heatOnPin, 3))
            else $error("control output not passed through");
    a_unmapped_zero:
        assert property (rdDone && avsAddress > 5'h14 |-> avsReadData == 32'h0000_0000)
            else $error("unmapped read not zero");
    a_sensor_off:
        assert property (!sensePresent [*8] |-> !heaterOpenAlarm)
            else $error("alarm raised without a sensor");
    a_thresh_range:
        assert property (rdDone && avsAddress == hoa_pkg::OFS_THRESH
            |-> avsReadData <= 32'h0000_03E8) else $error("threshold out of range");
    a_hyst_range:
        assert property (rdDone && avsAddress == hoa_pkg::OFS_HYST
            |-> avsReadData >= 32'h0000_0001 && avsReadData <= 32'h0000_03E8)
            else $error("hysteresis out of range");
    a_monitor_range:
        assert property (rdDone && avsAddress == hoa_pkg::OFS_MONITOR
            |-> avsReadData <= 32'h0000_044C) else $error("monitor out of range");
    c_alarm_rise: cover property ($rose(heaterOpenAlarm));
    c_alarm_fall: cover property ($fell(heaterOpenAlarm));
    c_write_done: cover property (avsWrite && !avsWaitRequest);
endmodule
bind hoa_top hoa_checker u_chk (.*);

// File: dv/hoa_ct_model.sv
// current transformer model: senses the heater line while it is powered
module hoa_ct_model (
    input wire logic        clk,
    input wire logic        heatOn,       // heater powered by the control output
    input wire logic [10:0] loadCurrent,  // draw of the heater when powered
    output logic     [10:0] senseCurrent  // sensed current, tenths of amps
);
    timeunit 1ns;
    timeprecision 1ps;
    // an unpowered heater draws nothing, so the loop reads zero
    always_ff @(posedge clk) begin
        senseCurrent <= heatOn ? loadCurrent : 11'h000;
    end
endmodule

// File: dv/testbench.sv
// self-checking bench for the heater-open alarm block
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
    $display("CHECK FAILED %0t got %0h", $time, a); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [10:0] thr;   // threshold
        logic [10:0] hys;   // hysteresis
        logic [10:0] cur;   // heater draw
        int          on;    // on cycles
        logic        cool;  // drive cooling instead
        logic        exp;   // alarm afterwards
    } hoa_row_t;
    // normal 5.0 A against open 0.0 A: a wide gap, threshold from one heater
    hoa_row_t rows[16] = '{
        '{11'h019, 11'h001, 11'h032, 60, 0, 0}, '{11'h019, 11'h001, 11'h000, 60, 0, 1},
        '{11'h019, 11'h001, 11'h01A, 60, 0, 1}, '{11'h019, 11'h001, 11'h01B, 60, 0, 0},
        '{11'h019, 11'h001, 11'h000, 10, 0, 0}, '{11'h019, 11'h001, 11'h000, 60, 1, 0},
        '{11'h019, 11'h001, 11'h000, 60, 0, 1}, '{11'h019, 11'h001, 11'h032, 10, 0, 1},
        '{11'h000, 11'h001, 11'h000, 60, 0, 0}, '{11'h3E8, 11'h001, 11'h032, 60, 0, 1},
        '{11'h3E6, 11'h001, 11'h3E8, 60, 0, 0}, '{11'h3E7, 11'h001, 11'h1F4, 60, 0, 1},
        '{11'h001, 11'h001, 11'h003, 60, 0, 0}, '{11'h001, 11'h001, 11'h000, 60, 0, 1},
        '{11'h019, 11'h3E8, 11'h032, 60, 0, 1}, '{11'h019, 11'h001, 11'h4B0, 60, 0, 0}};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        clkEn = 1'b1;
    logic        heatOnPin = 1'b0;
    logic        coolOnPin = 1'b0;
    logic        sensePresent = 1'b1;
    logic [10:0] loadCurrent = 11'h000;
    logic [10:0] senseCurrent;
    logic [4:0]  avsAddress = 5'h00;
    logic        avsRead = 1'b0;
    logic        avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h0000_0000;
    logic [3:0]  avsByteEnable = 4'hF;
    logic [31:0] avsReadData;
    logic        avsWaitRequest;
    logic        heaterOpenAlarm;
    logic        heatOut;
    int          failures = 0;
    int          compares = 0;
    int          cycles = 0;
    hoa_top #(.SKIP_CYCLES(20)) DUT (.clk(clk), .rst(rst), .clkEn(clkEn),
        .heatOnPin(heatOnPin), .coolOnPin(coolOnPin), .senseCurrent(senseCurrent),
        .sensePresent(sensePresent), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
        .heaterOpenAlarm(heaterOpenAlarm), .heatOut(heatOut));
    hoa_ct_model u_ct (.clk(clk), .heatOn(heatOut), .loadCurrent(loadCurrent),
        .senseCurrent(senseCurrent));
    always #4 clk = ~clk;
    //////////////////////////////////////////////////////////////////////////
    // one bus cycle: hold everything until waitrequest is seen low
    task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        avsAddress   <= a;
        avsRead      <= !w;
        avsWrite     <= w;
        avsWriteData <= d;
        // no local limit: only the bench timeout ends a wait that never ends
        do begin
            @(posedge clk);
        end while (avsWaitRequest !== 1'b0);
        q = avsReadData;
        avsRead  <= 1'b0;
        avsWrite <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask
    task automatic rchk(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0000_0000, q);
        `CHK(q, e)
    endtask
    // one control-on interval, with the monitor read while still on when heating lasts over 30 cycles
    task automatic heat(input logic [10:0] cur, input int n, input logic cool);
        loadCurrent <= cur;
        if (cool)
            coolOnPin <= 1'b1;
        else
            heatOnPin <= 1'b1;
        repeat (n) @(posedge clk);
        if (n > 30 && !cool)
            rchk(hoa_pkg::OFS_MONITOR, 32'(cur > 11'h44C ? 11'h44C : cur));
        heatOnPin <= 1'b0;
        coolOnPin <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    task automatic end_of_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // a hang counts as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == 12000) begin
            failures++;
            end_of_test();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        wr(hoa_pkg::OFS_CTRL, 32'h0000_0002);
        foreach (rows[i]) begin
            wr(hoa_pkg::OFS_THRESH, 32'(rows[i].thr));
            wr(hoa_pkg::OFS_HYST, 32'(rows[i].hys));
            heat(rows[i].cur, rows[i].on, rows[i].cool);
            `CHK(heaterOpenAlarm, rows[i].exp)
            rchk(hoa_pkg::OFS_STATUS, 32'({2'b11, rows[i].exp}));
            $display("row %0d done", i);
        end
        // clamps, a write without lane 0 and an unmapped word
        wr(hoa_pkg::OFS_THRESH, 32'h0000_07D0);
        rchk(hoa_pkg::OFS_THRESH, 32'h0000_03E8);
        wr(hoa_pkg::OFS_HYST, 32'h0000_0000);
        rchk(hoa_pkg::OFS_HYST, 32'h0000_0001);
        avsByteEnable <= 4'hE;
        wr(hoa_pkg::OFS_THRESH, 32'h0000_0019);
        avsByteEnable <= 4'hF;
        rchk(hoa_pkg::OFS_THRESH, 32'h0000_03E8);
        wr(5'h18, 32'h0000_FFFF);
        rchk(5'h18, 32'h0000_0000);
        sensePresent <= 1'b0;
        heat(11'h000, 60, 1'b0);
        `CHK(heaterOpenAlarm, 1'b0)
        rchk(hoa_pkg::OFS_STATUS, 32'h0000_0002);
        // a low enable freezes all state, so the returning sensor is not seen yet
        clkEn        <= 1'b0;
        sensePresent <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK(heaterOpenAlarm, 1'b0)
        clkEn <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK(heaterOpenAlarm, 1'b1)
        $display("register test done");
        // latched alarm cleared three ways: error reset, soft reset, zero threshold
        wr(hoa_pkg::OFS_CTRL, 32'h0000_0003);
        wr(hoa_pkg::OFS_THRESH, 32'h0000_0019);
        for (int k = 0; k < 3; k++) begin
            heat(11'h000, 60, 1'b0);
            heat(11'h032, 60, 1'b0);
            `CHK(heaterOpenAlarm, 1'b1)
            if (k == 2)
                wr(hoa_pkg::OFS_THRESH, 32'h0000_0000);
            else
                wr(hoa_pkg::OFS_CMD, 32'(k + 1));
            repeat (4) @(posedge clk);
            `CHK(heaterOpenAlarm, 1'b0)
        end
        $display("latch test done");
        // a second reset clears a latched alarm and restores defaults
        wr(hoa_pkg::OFS_THRESH, 32'h0000_0019);
        heat(11'h000, 60, 1'b0);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK(heaterOpenAlarm, 1'b0)
        rchk(hoa_pkg::OFS_THRESH, 32'h0000_0000);
        rchk(hoa_pkg::OFS_HYST, 32'h0000_0001);
        rchk(hoa_pkg::OFS_CTRL, 32'h0000_0000);
        $display("reset test done");
        end_of_test();
    end
endmodule

// File: logic/hoa_cmp_if.sv
// interface carrying comparator inputs and verdict between the modules
interface hoa_cmp_if;
    logic [10:0] current;    // measured current, tenths of amps
    logic [10:0] thresh;     // detection threshold
    logic [10:0] hyst;       // hysteresis
    logic        below;      // current below threshold
    logic        above;      // current above threshold plus hysteresis
    modport ctl (output current, output thresh, output hyst, input below, input above);
    modport cmp (input current, input thresh, input hyst, output below, output above);
endinterface

// File: logic/hoa_compare.sv
// threshold comparator with hysteresis band
module hoa_compare (
    hoa_cmp_if.cmp cmp
);
    // widen before adding so thresh plus hyst cannot wrap
    logic [11:0] upper;    // release level
    assign upper      = {1'b0, cmp.thresh} + {1'b0, cmp.hyst};
    assign cmp.below  = cmp.current < cmp.thresh;
    assign cmp.above  = {1'b0, cmp.current} > upper;
endmodule

// File: logic/hoa_pkg.sv
// package of constants and types for the heater-open alarm block
package hoa_pkg;
    // currents are in tenths of an ampere
    localparam int            CUR_W         = 11;
    localparam logic [10:0]   THR_OFF       = 11'h000;   // forces alarm off
    localparam logic [10:0]   THR_ON        = 11'h3E8;   // 100.0 A, forces alarm on
    localparam logic [10:0]   HYS_MIN       = 11'h001;   // 0.1 A
    localparam logic [10:0]   HYS_MAX       = 11'h3E8;   // 100.0 A
    localparam logic [10:0]   HYS_RST       = 11'h001;   // 0.1 A default
    localparam logic [10:0]   MON_MAX       = 11'h44C;   // 110.0 A
    localparam logic [10:0]   THR_RST       = 11'h000;   // 0.0 A default
    // register offsets, byte addresses, one word each
    localparam logic [4:0]    OFS_THRESH    = 5'h00;
    localparam logic [4:0]    OFS_HYST      = 5'h04;
    localparam logic [4:0]    OFS_CTRL      = 5'h08;
    localparam logic [4:0]    OFS_CMD       = 5'h0C;
    localparam logic [4:0]    OFS_MONITOR   = 5'h10;
    localparam logic [4:0]    OFS_STATUS    = 5'h14;
    // control bit positions
    localparam int            CTRL_LATCH    = 0;
    localparam int            CTRL_ATYPE_LO = 1;
    localparam int            CTRL_ATYPE_W  = 4;
    // command bit positions
    localparam int            CMD_ERR_RST   = 0;
    localparam int            CMD_SW_RST    = 1;
    // status bit positions
    localparam int            STS_ALARM     = 0;
    localparam int            STS_VALID     = 1;
    localparam int            STS_CT        = 2;
    // timing
    localparam int            CLK_HZ        = 125_000_000;
    localparam int            SKIP_MS       = 100;
    localparam int            SKIP_CYC      = SKIP_MS * (CLK_HZ / 1000);
    // on-interval tracking states
    typedef enum logic [1:0] {
        HOA_IDLE  = 2'b00,   // heating off
        HOA_SHORT = 2'b01,   // on, 100 ms not yet passed
        HOA_EVAL  = 2'b10    // on long enough to judge
    } hoa_state_t;
endpackage

// File: logic/hoa_top.sv
// heater-open alarm: current sampling, detection, latch and avalon registers

//
// overview
// - heating and cooling levels and the sensor-present level come from pins and
//   pass two flip-flops before any logic reads them
// - the current word passes two register stages as well; it is a sampled bus, so a
//   torn word can appear for a cycle, but judging waits out the skip window first
// - thresholds and currents share one unit, tenths of an ampere, so no scaling
//   is needed between the registers and the comparator
// - the monitor follows the sampled current only while heating is on, so software
//   reads the last on-time draw after heating stops
// - an on-interval is judged only once the skip counter has run out; shorter
//   intervals leave the alarm exactly as it was
// - cooling is synchronised for completeness but never starts an interval
//
// alarm priority, highest first
// - no sensor fitted: alarm held off
// - threshold at full scale: alarm forced on
// - threshold at zero: alarm forced off
// - judged current below threshold: alarm raised, even over a clear in the same cycle
// - latched alarm: held until a clear pulse arrives
// - judged current above threshold plus hysteresis: alarm released
// - clear pulse on an unlatched alarm: alarm dropped
//
// register map, one word each, data in the low bits
// - threshold, hysteresis, control (latch and alarm type), command pulses
// - monitor and status are read only; status shows alarm, type set and sensor fitted
//
// bus timing
// - a request seen at one edge drops waitrequest after that edge
// - the next edge completes it: write data lands, read data already stands
// - waitrequest rises again straight after, so every access costs two cycles
// - writes need byte lane 0; other lanes alone are ignored
// - unmapped reads return zero, unmapped writes are dropped
//
// latency from the heating pin
// - two cycles to the synchronised level, one more to the interval state
// - the pass-through control copy trails the pin by three cycles
// - the sampled current reaches the monitor three cycles after the sense word changes
// - the alarm output trails the internal alarm state by one register
//
// limitations
// - the skip window counts cycles of this clock; a slower clock needs a new count
// - the hysteresis sum is formed one bit wider, so full-scale settings cannot wrap
// - the clock enable freezes the bus answer too, so a master must not time out on it
// - a write of zero to the threshold both forces the alarm off and clears the latch
// - the soft reset command clears only the latch, configuration is kept
// - alarm type is stored and reported but does not gate detection

//////////////////////////////////////////////////////////////////////////////
module hoa_top #(
    parameter int SKIP_CYCLES = hoa_pkg::SKIP_CYC    // minimum judged on-time
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        clkEn,          // freezes all state when low
    input  wire logic        heatOnPin,      // heating control output, asynchronous
    input  wire logic        coolOnPin,      // cooling control output, asynchronous
    input  wire logic [10:0] senseCurrent,   // current sense sample, tenths of amps
    input  wire logic        sensePresent,   // current sensor fitted
    input  wire logic [4:0]  avsAddress,
    input  wire logic        avsRead,
    input  wire logic        avsWrite,
    input  wire logic [31:0] avsWriteData,
    input  wire logic [3:0]  avsByteEnable,
    output logic [31:0]      avsReadData,
    output logic             avsWaitRequest,
    output logic             heaterOpenAlarm, // alarm output level
    output logic             heatOut          // control output passed through untouched
);
    // elaboration guard: a zero skip count would judge every on-interval at once
    if (SKIP_CYCLES < 1) begin : g_bad_skip
        $error("SKIP_CYCLES must be at least 1");
    end

    //////////////////////////////////////////////////////////////////////////
    // synchronisers
    logic [1:0]  heatSync_r;      // heating pin, two stages
    logic [1:0]  coolSync_r;      // cooling pin, two stages
    logic [1:0]  presSync_r;      // sensor-present pin, two stages
    logic [10:0] curS1_r;         // current first stage
    logic [10:0] curS2_r;         // current second stage
    // multi-bit sample may tear; a following stage below filters by on-time
    always_ff @(posedge clk) begin
        if (rst) begin
            heatSync_r <= 2'b00;
            coolSync_r <= 2'b00;
            presSync_r <= 2'b00;
            curS1_r    <= 11'h000;
            curS2_r    <= 11'h000;
        end else if (clkEn) begin
            heatSync_r <= {heatSync_r[0], heatOnPin};
            coolSync_r <= {coolSync_r[0], coolOnPin};
            presSync_r <= {presSync_r[0], sensePresent};
            curS1_r    <= senseCurrent;
            curS2_r    <= curS1_r;
        end
    end

    logic heatOn;     // synchronised heating level
    logic ctPresent;  // synchronised sensor presence
    assign heatOn    = heatSync_r[1];
    assign ctPresent = presSync_r[1];

    //////////////////////////////////////////////////////////////////////////
    // register file
    logic [10:0] thresh_r;         // detection threshold
    logic [10:0] hyst_r;           // hysteresis
    logic        latchEn_r;        // latch enable
    logic [3:0]  alarmType_r;      // alarm type, zero means unused
    logic [10:0] monitor_r;        // last on-time current
    logic        alarm_r;          // alarm state
    logic        clrPulse_r;       // one-cycle latch clear from software
    logic        wrAck_r;          // answer phase flag

    function automatic logic [10:0] clampCur(input logic [10:0] v, input logic [10:0] lim);
        clampCur = (v > lim) ? lim : v;
    endfunction

    logic acc;        // bus request present, not yet answered
    logic wrHit;      // write accepted this cycle
    assign acc   = (avsRead || avsWrite) && !wrAck_r;
    assign wrHit = avsWrite && wrAck_r;

    // one wait cycle, then the access completes
    always_ff @(posedge clk) begin
        if (rst) begin
            wrAck_r <= 1'b0;
        end else if (clkEn) begin
            wrAck_r <= acc;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            avsWaitRequest <= 1'b1;
        end else if (clkEn) begin
            avsWaitRequest <= !acc;
        end
    end

    // configuration writes
    always_ff @(posedge clk) begin
        if (rst) begin
            thresh_r    <= hoa_pkg::THR_RST;
            hyst_r      <= hoa_pkg::HYS_RST;
            latchEn_r   <= 1'b0;
            alarmType_r <= 4'h0;
        end else if (clkEn && wrHit && avsByteEnable[0]) begin
            if (avsAddress == hoa_pkg::OFS_THRESH) begin
                thresh_r <= clampCur(avsWriteData[10:0], hoa_pkg::THR_ON);
            end else if (avsAddress == hoa_pkg::OFS_HYST) begin
                // out-of-range hysteresis is pinned to the legal band
                if (avsWriteData[10:0] < hoa_pkg::HYS_MIN) begin
                    hyst_r <= hoa_pkg::HYS_MIN;
                end else begin
                    hyst_r <= clampCur(avsWriteData[10:0], hoa_pkg::HYS_MAX);
                end
            end else if (avsAddress == hoa_pkg::OFS_CTRL) begin
                latchEn_r   <= avsWriteData[hoa_pkg::CTRL_LATCH];
                alarmType_r <= avsWriteData[hoa_pkg::CTRL_ATYPE_LO +: hoa_pkg::CTRL_ATYPE_W];
            end
        end
    end

    // command register: self-clearing pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            clrPulse_r <= 1'b0;
        end else if (clkEn) begin
            clrPulse_r <= 1'b0;
            if (wrHit && avsByteEnable[0]) begin
                if (avsAddress == hoa_pkg::OFS_CMD) begin
                    clrPulse_r <= avsWriteData[hoa_pkg::CMD_ERR_RST]
                                || avsWriteData[hoa_pkg::CMD_SW_RST];
                end else if (avsAddress == hoa_pkg::OFS_THRESH
                             && avsWriteData[10:0] == hoa_pkg::THR_OFF) begin
                    clrPulse_r <= 1'b1;
                end
            end
        end
    end

    // read data path, unmapped addresses read zero
    always_ff @(posedge clk) begin
        if (rst) begin
            avsReadData <= 32'h0000_0000;
        end else if (clkEn && acc && avsRead) begin
            if (avsAddress == hoa_pkg::OFS_THRESH) begin
                avsReadData <= {21'h00_0000, thresh_r};
            end else if (avsAddress == hoa_pkg::OFS_HYST) begin
                avsReadData <= {21'h00_0000, hyst_r};
            end else if (avsAddress == hoa_pkg::OFS_CTRL) begin
                avsReadData <= {27'h000_0000, alarmType_r, latchEn_r};
            end else if (avsAddress == hoa_pkg::OFS_MONITOR) begin
                avsReadData <= {21'h00_0000, monitor_r};
            end else if (avsAddress == hoa_pkg::OFS_STATUS) begin
                avsReadData <= {29'h0000_0000, ctPresent,
                                (alarmType_r != 4'h0), alarm_r};
            end else begin
                avsReadData <= 32'h0000_0000;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // on-interval tracking
    hoa_pkg::hoa_state_t state_r;  // interval state
    logic [31:0]         onCnt_r;  // cycles since heating came on

    // cooling never enters the judgement; only heating starts an interval
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= hoa_pkg::HOA_IDLE;
            onCnt_r <= 32'h0000_0000;
        end else if (clkEn) begin
            case (state_r)
                hoa_pkg::HOA_IDLE: begin
                    onCnt_r <= 32'h0000_0000;
                    if (heatOn) begin
                        state_r <= hoa_pkg::HOA_SHORT;
                    end
                end
                hoa_pkg::HOA_SHORT: begin
                    if (!heatOn) begin
                        state_r <= hoa_pkg::HOA_IDLE;
                    end else if (onCnt_r >= 32'(SKIP_CYCLES)) begin
                        state_r <= hoa_pkg::HOA_EVAL;
                    end else begin
                        onCnt_r <= onCnt_r + 32'h0000_0001;
                    end
                end
                hoa_pkg::HOA_EVAL: begin
                    if (!heatOn) begin
                        state_r <= hoa_pkg::HOA_IDLE;
                    end
                end
                default: begin
                    state_r <= hoa_pkg::HOA_IDLE;
                end
            endcase
        end
    end

    // monitor follows the current while heating is on, pinned to full scale
    always_ff @(posedge clk) begin
        if (rst) begin
            monitor_r <= 11'h000;
        end else if (clkEn && heatOn) begin
            monitor_r <= clampCur(curS2_r, hoa_pkg::MON_MAX);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // comparator and alarm
    hoa_cmp_if cmpBus ();
    assign cmpBus.current = monitor_r;
    assign cmpBus.thresh  = thresh_r;
    assign cmpBus.hyst    = hyst_r;

    hoa_compare uCmp (
        .cmp (cmpBus)
    );

    logic forceOff;  // threshold set to 0.0
    logic forceOn;   // threshold set to 100.0
    logic judging;   // a real comparison may act now
    assign forceOff = thresh_r == hoa_pkg::THR_OFF;
    assign forceOn  = thresh_r >= hoa_pkg::THR_ON;
    assign judging  = ctPresent && state_r == hoa_pkg::HOA_EVAL
                      && heatOn && !forceOff && !forceOn;

    // a raise in the same cycle as a clear wins
    always_ff @(posedge clk) begin
        if (rst) begin
            alarm_r <= 1'b0;
        end else if (clkEn) begin
            if (!ctPresent) begin
                alarm_r <= 1'b0;
            end else if (forceOn) begin
                alarm_r <= 1'b1;
            end else if (forceOff) begin
                alarm_r <= 1'b0;
            end else if (judging && cmpBus.below) begin
                alarm_r <= 1'b1;
            end else if (latchEn_r && alarm_r) begin
                alarm_r <= !clrPulse_r;
            end else if (judging && cmpBus.above) begin
                alarm_r <= 1'b0;
            end else if (clrPulse_r) begin
                alarm_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            heaterOpenAlarm <= 1'b0;
        end else if (clkEn) begin
            heaterOpenAlarm <= alarm_r;
        end
    end

    // control path is a plain registered copy, the alarm never enters it
    always_ff @(posedge clk) begin
        if (rst) begin
            heatOut <= 1'b0;
        end else if (clkEn) begin
            heatOut <= heatSync_r[1];
        end
    end

    // cooling is sampled but deliberately excluded from detection
    logic coolOn;
    assign coolOn = coolSync_r[1];
endmodule
